// ### design/dps_scheduler.sv
`timescale 1ns/1ps
`include "dps_defs.svh"

// What this block does
// - A pair of short-decodable instructions enters as one set of four operation entries.
// - The buffer holds at most six sets, 24 operation entries in all.
// - Sets move down in order and retire only from the bottom position.
// - An unfinished bottom set stalls entry of new operations once all six positions hold sets, until a position frees.
// - Without stalls each set position is one clock of progress toward execution.
// - A load takes two cycles; a consumer fewer than two pairs later waits the rest.
// - Packed vector arithmetic takes two cycles; its memory form adds the load first.
// - The first store to a freshly filled, unwritten line takes one extra cycle.
// - A prefetch starts a 32 byte fill whose first data feeds waiting loads early.
// - Instructions reaching the end of a 32-byte code line lose short predecode.
// - The source-index-register-only memory mode fails predecode.
// - Vector instructions with a sib byte and mod 00b fail predecode.
// - A vector float instruction failing predecode still takes one long decode.

module dps_scheduler (
   // Clock and reset
   input  wire logic                  ref_clk,
   input  wire logic                  reset,
   // Decode pair
   input  wire logic                  pair_valid,
   input  wire dps_pkg::dps_insn_type [1:0] pair_insn,
   input  wire dps_pkg::dps_set_type  pair_ops,
   output logic                       pair_ready,
   output logic                       taken_short,
   output logic                       taken_long,
   output logic                       pair_rejected,
   // Scheduler status
   output logic                       retire,
   output logic                       sched_stall,
   output logic [2:0]                 occupancy,
   // Line fill
   input  wire logic                  fill_beat_valid,
   input  wire logic [63:0]           fill_beat_data,
   output logic                       fill_busy,
   output logic [7:0]                 fill_line,
   output logic                       fwd_valid,
   output logic [63:0]                fwd_data
);
   import dps_pkg::*;

   dps_state_type       s;
   dps_state_type       next_s;
   dps_pdec_type [1:0]  pdec;
   logic                fill_first;
   logic                fill_done;
   logic                fill_start;
   logic [7:0]          fill_start_line;
   logic [5:0]          move;
   logic [5:0]          next_move;
   logic                accept;
   logic                pair_short;
   logic                pair_long;
   dps_entry_type       new_entry;
   dps_entry_type [5:0] dec;
   logic                store_extra;

   ////////////////////////////////////////////////////////////////////////////
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++)
      begin : g_pdec
         dps_predecode u_pdec (
            .insn   (pair_insn[gi]),
            .result (pdec[gi])
         );
      end
   endgenerate

   dps_line_fill u_fill (
      .ref_clk    (ref_clk),
      .reset      (reset),
      .start      (fill_start),
      .start_line (fill_start_line),
      .beat_valid (fill_beat_valid),
      .beat_data  (fill_beat_data),
      .busy       (fill_busy),
      .line       (fill_line),
      .first_seen (fill_first),
      .fwd_valid  (fwd_valid),
      .fwd_data   (fwd_data),
      .done       (fill_done)
   );

   ////////////////////////////////////////////////////////////////////////////
   function automatic logic slot_done(input dps_entry_type e);
      logic d;
      d = 1'b1;
      for (int k = 0; k < `DPS_OPS; k++)
      begin
         if (e.cnt[k] != 3'h0)
         begin
            d = 1'b0;
         end
      end
      return d;
   endfunction

   // Bottom moves out when done; every other set drops into a free or freeing spot
   function automatic logic [5:0] calc_move(input dps_entry_type [5:0] sl);
      logic [5:0] m;
      m[5] = sl[5].valid && slot_done(sl[5]);
      for (int i = `DPS_SETS - 2; i >= 0; i--)
      begin
         m[i] = sl[i].valid && (!sl[i + 1].valid || m[i + 1]);
      end
      return m;
   endfunction

   function automatic logic [2:0] base_lat(input dps_kind_type k);
      logic [2:0] l;
      unique case (k)
         DPS_K_LOAD:    l = `DPS_LOAD_LAT;
         DPS_K_VEC:     l = `DPS_VEC_LAT;
         DPS_K_VEC_MEM: l = `DPS_LOAD_LAT + `DPS_VEC_LAT;
         default:       l = `DPS_ONE_LAT;
      endcase
      return l;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      next_s          = s;
      move            = calc_move(s.slot);
      pair_short      = pdec[0].short_ok && pdec[1].short_ok;
      pair_long       = !pair_short && (pdec[0].short_ok || pdec[0].long_ok)
                        && (pdec[1].short_ok || pdec[1].long_ok);
      accept          = pair_valid && s.ready && (pair_short || pair_long);
      fill_start      = 1'b0;
      fill_start_line = 8'h00;
      store_extra     = 1'b0;

      // Build the incoming set; latencies count from the cycle after entry
      new_entry.valid = 1'b1;
      new_entry.ops   = pair_ops.ops;
      for (int k = 0; k < `DPS_OPS; k++)
      begin
         new_entry.cnt[k] = 3'h0;
         if (pair_ops.ops[k].valid)
         begin
            new_entry.cnt[k] = base_lat(pair_ops.ops[k].kind);
            if (pair_ops.ops[k].dep_dist != 3'h0
                && pair_ops.ops[k].dep_dist < `DPS_LOAD_PAIRS)
            begin
               new_entry.cnt[k] = new_entry.cnt[k]
                                  + (`DPS_LOAD_PAIRS - pair_ops.ops[k].dep_dist);
            end
            if (pair_ops.ops[k].kind == DPS_K_STORE && s.fresh_valid
                && !s.fresh_written && pair_ops.ops[k].line == s.fresh_line)
            begin
               new_entry.cnt[k] = new_entry.cnt[k] + `DPS_STORE_EXTRA;
               store_extra      = 1'b1;
            end
            if (pair_ops.ops[k].kind == DPS_K_PREFETCH && accept && !fill_busy
                && !fill_start)
            begin
               fill_start      = 1'b1;
               fill_start_line = pair_ops.ops[k].line;
            end
         end
      end

      // Count down; a load on the filling line waits for the forwarded beat
      for (int i = 0; i < `DPS_SETS; i++)
      begin
         dec[i] = s.slot[i];
         for (int k = 0; k < `DPS_OPS; k++)
         begin
            if (s.slot[i].cnt[k] != 3'h0
                && !(s.slot[i].ops[k].kind == DPS_K_LOAD && fill_busy && !fill_first
                     && s.slot[i].ops[k].line == fill_line))
            begin
               dec[i].cnt[k] = s.slot[i].cnt[k] - 3'h1;
            end
         end
      end

      // One position per clock downward
      for (int i = 0; i < `DPS_SETS; i++)
      begin
         if (i > 0 && move[i - 1])
         begin
            next_s.slot[i] = dec[i - 1];
         end
         else if (move[i])
         begin
            next_s.slot[i]       = dec[i];
            next_s.slot[i].valid = 1'b0;
         end
         else
         begin
            next_s.slot[i] = dec[i];
         end
      end
      if (accept)
      begin
         next_s.slot[0] = new_entry;
      end

      if (accept && store_extra)
      begin
         next_s.fresh_written = 1'b1;
      end
      // A completed fill supersedes any store marking in the same cycle
      if (fill_done)
      begin
         next_s.fresh_line    = fill_line;
         next_s.fresh_valid   = 1'b1;
         next_s.fresh_written = 1'b0;
      end

      next_s.occupancy = 3'h0;
      for (int i = 0; i < `DPS_SETS; i++)
      begin
         next_s.occupancy = next_s.occupancy + {2'h0, next_s.slot[i].valid};
      end
      next_move          = calc_move(next_s.slot);
      next_s.ready       = !next_s.slot[0].valid || next_move[0];
      next_s.stall       = next_s.slot[5].valid && !slot_done(next_s.slot[5])
                           && !next_s.ready;
      next_s.retire      = move[5];
      next_s.taken_short = accept && pair_short;
      next_s.taken_long  = accept && pair_long;
      next_s.rejected    = pair_valid && s.ready && !pair_short && !pair_long;
   end

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         s       <= '0;
         s.ready <= 1'b1;
      end
      else
      begin
         s <= next_s;
      end
   end

   assign pair_ready    = s.ready;
   assign taken_short   = s.taken_short;
   assign taken_long    = s.taken_long;
   assign pair_rejected = s.rejected;
   assign retire        = s.retire;
   assign sched_stall   = s.stall;
   assign occupancy     = s.occupancy;

   ////////////////////////////////////////////////////////////////////////////
   property p_set_entry;
      @(posedge ref_clk) disable iff (reset)
      accept |=> (s.slot[0].valid && s.slot[0].ops == $past(pair_ops.ops) && taken_short
                  == $past(pair_short));
   endproperty
   a_set_entry: assert property (p_set_entry)
      else $error("accepted pair did not land as one set");

   property p_capacity;
      @(posedge ref_clk) disable iff (reset)
      occupancy <= `DPS_OCC_FULL;
   endproperty
   a_capacity: assert property (p_capacity)
      else $error("more than six sets held");

   property p_retire_bottom;
      @(posedge ref_clk) disable iff (reset)
      retire |-> ($past(s.slot[5].valid) && $past(slot_done(s.slot[5])));
   endproperty
   a_retire_bottom: assert property (p_retire_bottom)
      else $error("retire without a finished bottom set");

   property p_stall_blocks;
      @(posedge ref_clk) disable iff (reset)
      (occupancy == `DPS_OCC_FULL && !slot_done(s.slot[5])) |-> (!pair_ready && !accept);
   endproperty
   a_stall_blocks: assert property (p_stall_blocks)
      else $error("entry taken while full bottom set unfinished");

   property p_one_step;
      @(posedge ref_clk) disable iff (reset)
      move[1] |=> (s.slot[2].valid && s.slot[2].ops == $past(s.slot[1].ops));
   endproperty
   a_one_step: assert property (p_one_step)
      else $error("set did not advance one position");

   property p_load_lat;
      @(posedge ref_clk) disable iff (reset)
      (accept && pair_ops.ops[0].valid && pair_ops.ops[0].kind == DPS_K_LOAD
       && pair_ops.ops[0].dep_dist == 3'h0) |=> s.slot[0].cnt[0] == 3'h2;
   endproperty
   a_load_lat: assert property (p_load_lat)
      else $error("load latency not two cycles");

   property p_dep_wait;
      @(posedge ref_clk) disable iff (reset)
      (accept && pair_ops.ops[1].valid && pair_ops.ops[1].kind == DPS_K_PLAIN
       && pair_ops.ops[1].dep_dist == 3'h1) |=> s.slot[0].cnt[1] == 3'h2;
   endproperty
   a_dep_wait: assert property (p_dep_wait)
      else $error("consumer one pair behind a load not delayed");

   property p_vec_mem_lat;
      @(posedge ref_clk) disable iff (reset)
      (accept && pair_ops.ops[2].valid && pair_ops.ops[2].kind == DPS_K_VEC_MEM
       && pair_ops.ops[2].dep_dist == 3'h0) |=> s.slot[0].cnt[2] == 3'h4;
   endproperty
   a_vec_mem_lat: assert property (p_vec_mem_lat)
      else $error("vector memory form latency not four cycles");

   property p_first_store;
      @(posedge ref_clk) disable iff (reset)
      (accept && pair_ops.ops[3].valid && pair_ops.ops[3].kind == DPS_K_STORE
       && pair_ops.ops[3].dep_dist == 3'h0 && s.fresh_valid && !s.fresh_written
       && pair_ops.ops[3].line == s.fresh_line && !fill_done)
       |=> (s.slot[0].cnt[3] == 3'h2 && s.fresh_written);
   endproperty
   a_first_store: assert property (p_first_store)
      else $error("first store to fresh line lacks the extra cycle");

   property p_long_vfp;
      @(posedge ref_clk) disable iff (reset)
      (pair_valid && pair_ready && !pdec[0].short_ok && pair_insn[0].is_vfp
       && pdec[1].short_ok) |=> (taken_long && !pair_rejected);
   endproperty
   a_long_vfp: assert property (p_long_vfp)
      else $error("vector float predecode failure was rejected");

   property p_srcidx_fail;
      @(posedge ref_clk) disable iff (reset)
      (pair_valid && pair_insn[0].has_modrm && pair_insn[0].modrm[7:6] == 2'h0
       && pair_insn[0].modrm[2:0] == 3'h6) |-> !pdec[0].short_ok;
   endproperty
   a_srcidx_fail: assert property (p_srcidx_fail)
      else $error("source index mode passed predecode");

   property p_entry_ready;
      @(posedge ref_clk) disable iff (reset)
      $rose(s.slot[0].valid) |-> $past(pair_ready && pair_valid);
   endproperty
   a_entry_ready: assert property (p_entry_ready)
      else $error("set entered without a free top position");

   c_stall:   cover property (@(posedge ref_clk) disable iff (reset) sched_stall);
   c_long:    cover property (@(posedge ref_clk) disable iff (reset) taken_long);
   c_forward: cover property (@(posedge ref_clk) disable iff (reset) fwd_valid);
   c_full:    cover property (@(posedge ref_clk) disable iff (reset)
                              occupancy == `DPS_OCC_FULL && retire);

endmodule

// ### design/dps_defs.svh
`ifndef DPS_DEFS_SVH
`define DPS_DEFS_SVH

// Scheduler geometry
`define DPS_SETS         6
`define DPS_OPS          4
`define DPS_ENTRIES      24
`define DPS_OCC_FULL     3'h6

// Clock period in ns; execution latencies in cycles of ref_clk
`define DPS_CLK_PERIOD_NS 10
`define DPS_ONE_LAT      3'h1
`define DPS_LOAD_LAT     3'h2
`define DPS_VEC_LAT      3'h2
`define DPS_LOAD_PAIRS   3'h2
`define DPS_STORE_EXTRA  3'h1

// Line fill
`define DPS_LINE_BYTES   6'h20
`define DPS_FILL_BEATS   3'h4
`define DPS_LAST_BEAT    2'h3

// Address mode encodings of the mod/rm byte
`define DPS_MOD_NONE     2'h0
`define DPS_RM_SIB       3'h4
`define DPS_RM_SRCIDX    3'h6

`endif

// ### design/dps_pkg.sv
package dps_pkg;

   typedef enum logic [2:0]
   {
      DPS_K_PLAIN    = 3'h0,
      DPS_K_LOAD     = 3'h1,
      DPS_K_STORE    = 3'h2,
      DPS_K_VEC      = 3'h3,
      DPS_K_VEC_MEM  = 3'h4,
      DPS_K_PREFETCH = 3'h5
   } dps_kind_type;

   typedef struct packed
   {
      logic         valid;
      dps_kind_type kind;
      logic [2:0]   dep_dist;
      logic [7:0]   line;
   } dps_op_type;

   typedef struct packed
   {
      dps_op_type [3:0] ops;
   } dps_set_type;

   typedef struct packed
   {
      logic             valid;
      dps_op_type [3:0] ops;
      logic [3:0][2:0]  cnt;
   } dps_entry_type;

   typedef struct packed
   {
      logic [4:0] offset;
      logic [3:0] length;
      logic       has_modrm;
      logic [7:0] modrm;
      logic       is_vec;
      logic       is_vfp;
   } dps_insn_type;

   typedef struct packed
   {
      logic short_ok;
      logic long_ok;
   } dps_pdec_type;

   typedef enum logic [1:0]
   {
      DPS_F_IDLE = 2'b01,
      DPS_F_BUSY = 2'b10
   } dps_fill_fsm_type;

   typedef struct packed
   {
      dps_fill_fsm_type fsm;
      logic [1:0]       beats;
      logic [7:0]       line;
      logic             first_seen;
      logic             fwd_valid;
      logic [63:0]      fwd_data;
      logic             done;
   } dps_fill_state_type;

   typedef struct packed
   {
      dps_entry_type [5:0] slot;
      logic                ready;
      logic                retire;
      logic                stall;
      logic                taken_short;
      logic                taken_long;
      logic                rejected;
      logic [2:0]          occupancy;
      logic [7:0]          fresh_line;
      logic                fresh_valid;
      logic                fresh_written;
   } dps_state_type;

endpackage

// ### design/dps_predecode.sv
`timescale 1ns/1ps
`include "dps_defs.svh"

module dps_predecode (
   // Instruction seen by predecode
   input  wire dps_pkg::dps_insn_type insn,
   // Result
   output dps_pkg::dps_pdec_type      result
);
   import dps_pkg::*;

   logic [5:0] end_pos;
   logic       end_fail;
   logic       srcidx_fail;
   logic       sib_fail;
   logic       fail;

   always_comb
   begin
      end_pos     = {1'b0, insn.offset} + {2'h0, insn.length};
      // Reaching the last byte of the line degrades predecode
      end_fail    = end_pos >= `DPS_LINE_BYTES;
      srcidx_fail = insn.has_modrm && insn.modrm[7:6] == `DPS_MOD_NONE
                    && insn.modrm[2:0] == `DPS_RM_SRCIDX;
      sib_fail    = insn.is_vec && insn.has_modrm
                    && insn.modrm[7:6] == `DPS_MOD_NONE
                    && insn.modrm[2:0] == `DPS_RM_SIB;
      fail        = end_fail || srcidx_fail || sib_fail;
      result.short_ok = !fail;
      // Vector float still goes through the long hardware decode
      result.long_ok  = fail && insn.is_vfp;
   end

endmodule

// ### design/dps_line_fill.sv
`timescale 1ns/1ps
`include "dps_defs.svh"

module dps_line_fill (
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        reset,
   // Fill start
   input  wire logic        start,
   input  wire logic [7:0]  start_line,
   // Beats from the memory side
   input  wire logic        beat_valid,
   input  wire logic [63:0] beat_data,
   // Status and forwarding
   output logic             busy,
   output logic [7:0]       line,
   output logic             first_seen,
   output logic             fwd_valid,
   output logic [63:0]      fwd_data,
   output logic             done
);
   import dps_pkg::*;

   dps_fill_state_type s;
   dps_fill_state_type next_s;

   always_comb
   begin
      next_s           = s;
      next_s.fwd_valid = 1'b0;
      next_s.done      = 1'b0;
      unique case (s.fsm)
         DPS_F_IDLE:
         begin
            // A start while busy is dropped; the running fill owns the buffer
            if (start)
            begin
               next_s.fsm        = DPS_F_BUSY;
               next_s.line       = start_line;
               next_s.beats      = 2'h0;
               next_s.first_seen = 1'b0;
            end
         end
         DPS_F_BUSY:
         begin
            if (beat_valid)
            begin
               if (!s.first_seen)
               begin
                  next_s.first_seen = 1'b1;
                  next_s.fwd_valid  = 1'b1;
                  next_s.fwd_data   = beat_data;
               end
               next_s.beats = s.beats + 2'h1;
               if (s.beats == `DPS_LAST_BEAT)
               begin
                  next_s.fsm  = DPS_F_IDLE;
                  next_s.done = 1'b1;
               end
            end
         end
      endcase
   end

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         s <= '{fsm: DPS_F_IDLE, beats: 2'h0, line: 8'h00, first_seen: 1'b0,
                fwd_valid: 1'b0, fwd_data: 64'h0, done: 1'b0};
      end
      else
      begin
         s <= next_s;
      end
   end

   assign busy       = s.fsm == DPS_F_BUSY;
   assign line       = s.line;
   assign first_seen = s.first_seen;
   assign fwd_valid  = s.fwd_valid;
   assign fwd_data   = s.fwd_data;
   assign done       = s.done;

   ////////////////////////////////////////////////////////////////////////////
   property p_fill_forward;
      @(posedge ref_clk) disable iff (reset)
      (busy && beat_valid && !first_seen) |=> (fwd_valid && fwd_data == $past(beat_data));
   endproperty
   a_fill_forward: assert property (p_fill_forward)
      else $error("first fill beat not forwarded");

   property p_fill_length;
      @(posedge ref_clk) disable iff (reset)
      done |-> ($past(s.beats) == `DPS_LAST_BEAT && $past(busy && beat_valid));
   endproperty
   a_fill_length: assert property (p_fill_length)
      else $error("fill ended after fewer than four beats");

   c_fill_done: cover property (@(posedge ref_clk) disable iff (reset) done);

endmodule

// ### tb/dps_mem_model.sv
`timescale 1ns/1ps
module dps_mem_model (
   // Clock and reset
   input  wire logic   ref_clk,
   input  wire logic   reset,
   // Fill side
   input  wire logic   fill_busy,
   input  wire logic   hold,
   output logic        beat_valid,
   output logic [63:0] beat_data
);
   logic [2:0] sent;
   always_ff @(posedge ref_clk)
   begin
      if (reset || !fill_busy)
         sent <= 3'h0;
      else if (beat_valid)
         sent <= sent + 3'h1;
      // Every other cycle, four beats of 64 bits per fill
      beat_valid <= !reset && fill_busy && !hold && !beat_valid && sent < 3'h4;
      // Between beats the bus flips, so a stale value never matches
      if (!reset && fill_busy && !hold && !beat_valid && sent < 3'h4)
         beat_data <= {32'hbeef_0000, 29'h0, sent};
      else
         beat_data <= ~beat_data;
   end
endmodule

// ### tb/testbench.sv
`timescale 1ns/1ps
module testbench;
   import dps_pkg::*;
   localparam dps_insn_type OK_I = '{5'h00, 4'h4, 1'b0, 8'h00, 1'b0, 1'b0};
   localparam dps_insn_type SRC_I = '{5'h00, 4'h4, 1'b1, 8'h06, 1'b0, 1'b0};
   localparam dps_insn_type SIB_I = '{5'h00, 4'h4, 1'b1, 8'h04, 1'b1, 1'b0};
   localparam dps_insn_type VFP_I = '{5'h00, 4'h4, 1'b1, 8'h04, 1'b1, 1'b1};
   localparam dps_insn_type END_I = '{5'h1c, 4'h4, 1'b0, 8'h00, 1'b0, 1'b0};
   localparam dps_insn_type FIT_I = '{5'h1b, 4'h4, 1'b0, 8'h00, 1'b0, 1'b0};
   logic               ref_clk = 1'b0;
   logic               reset = 1'b1;
   logic               pair_valid = 1'b0;
   dps_insn_type [1:0] pair_insn = '0;
   dps_set_type        pair_ops = '0;
   logic               hold = 1'b1;
   logic               pair_ready, taken_short, taken_long, pair_rejected;
   logic               retire, sched_stall, fill_busy, fwd_valid, beat_valid;
   logic [2:0]         occupancy;
   logic [7:0]         fill_line;
   logic [63:0]        beat_data, fwd_data;
   int                 errors = 0;
   int                 num_checks = 0;
   int                 cycles = 0;
   int                 retires = 0;
   int                 fwds = 0;
   dps_scheduler dut (.ref_clk(ref_clk), .reset(reset), .pair_valid(pair_valid),
      .pair_insn(pair_insn), .pair_ops(pair_ops), .pair_ready(pair_ready),
      .taken_short(taken_short), .taken_long(taken_long), .pair_rejected(pair_rejected),
      .retire(retire), .sched_stall(sched_stall), .occupancy(occupancy),
      .fill_beat_valid(beat_valid), .fill_beat_data(beat_data), .fill_busy(fill_busy),
      .fill_line(fill_line), .fwd_valid(fwd_valid), .fwd_data(fwd_data));
   dps_mem_model mem (.ref_clk(ref_clk), .reset(reset), .fill_busy(fill_busy),
      .hold(hold), .beat_valid(beat_valid), .beat_data(beat_data));
   always #5 ref_clk = ~ref_clk;
   ////////////////////////////////////////////////////////////////////////////
   task chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         errors++;
         $display("unexpected %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task finish_test;
      if (errors == 0 && num_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   always @(posedge ref_clk)
   begin
      cycles++;
      if (retire === 1'b1)
         retires++;
      if (cycles == 5000)
      begin
         errors++;
         finish_test();
      end
   end
   always @(negedge ref_clk)
   begin
      if (fwd_valid === 1'b1)
      begin
         fwds++;
         chk("fwd_data", fwd_data, {32'hbeef_0000, 32'h0});
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   function automatic dps_set_type mkset(input dps_kind_type k, input logic [7:0] ln);
      mkset.ops = {{3{1'b1, DPS_K_PLAIN, 3'h0, 8'h00}}, 1'b1, k, 3'h0, ln};
   endfunction
   // Holds the offer until ready is seen, drops it at the taking edge
   task send(input dps_insn_type a, b, input dps_set_type s, input int res);
      int n;
      @(posedge ref_clk);
      pair_valid <= 1'b1;
      pair_insn <= {b, a};
      pair_ops <= s;
      n = 0;
      @(negedge ref_clk);
      while (pair_ready !== 1'b1 && n < 100)
      begin
         @(negedge ref_clk);
         n++;
      end
      @(posedge ref_clk);
      pair_valid <= 1'b0;
      @(negedge ref_clk);
      chk("taken_short", taken_short, res == 0);
      chk("taken_long", taken_long, res == 1);
      chk("pair_rejected", pair_rejected, res == 2);
   endtask
   task drain;
      int n;
      n = 0;
      while (occupancy !== 3'h0 && n < 200)
      begin
         @(negedge ref_clk);
         n++;
      end
      repeat (2) @(negedge ref_clk);
      chk("occupancy", occupancy, 0);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task test_reset;
      chk("occupancy", occupancy, 0);
      chk("pair_ready", pair_ready, 1);
      chk("sched_stall", sched_stall, 0);
      chk("fill_busy", fill_busy, 0);
   endtask
   task test_flow;
      int k;
      send(OK_I, OK_I, mkset(DPS_K_PLAIN, 8'h00), 0);
      chk("occupancy", occupancy, 1);
      k = 1;
      while (retire !== 1'b1 && k < 20)
      begin
         @(negedge ref_clk);
         k++;
      end
      chk("retire_cycle", k, 7);
      chk("occupancy", occupancy, 0);
   endtask
   task test_predecode;
      send(SRC_I, OK_I, mkset(DPS_K_PLAIN, 8'h00), 2);
      send(SIB_I, OK_I, mkset(DPS_K_PLAIN, 8'h00), 2);
      send(VFP_I, OK_I, mkset(DPS_K_VEC, 8'h00), 1);
      send(END_I, OK_I, mkset(DPS_K_PLAIN, 8'h00), 2);
      send(FIT_I, OK_I, mkset(DPS_K_VEC_MEM, 8'h00), 0);
      drain();
   endtask
   // Loads wait on a fill held back by the memory side until the chain is full
   task test_stall;
      int n;
      retires = 0;
      fwds = 0;
      send(OK_I, OK_I, mkset(DPS_K_PREFETCH, 8'h5a), 0);
      @(negedge ref_clk);
      chk("fill_busy", fill_busy, 1);
      chk("fill_line", fill_line, 8'h5a);
      repeat (6) send(OK_I, OK_I, mkset(DPS_K_LOAD, 8'h5a), 0);
      repeat (4) @(negedge ref_clk);
      chk("occupancy", occupancy, 6);
      chk("pair_ready", pair_ready, 0);
      chk("sched_stall", sched_stall, 1);
      @(posedge ref_clk);
      pair_valid <= 1'b1;
      pair_ops <= mkset(DPS_K_STORE, 8'h5a);
      repeat (3)
      begin
         @(negedge ref_clk);
         chk("taken_short", taken_short, 0);
      end
      @(posedge ref_clk);
      hold <= 1'b0;
      n = 0;
      while (pair_ready !== 1'b1 && n < 200)
      begin
         @(negedge ref_clk);
         n++;
      end
      @(posedge ref_clk);
      pair_valid <= 1'b0;
      drain();
      chk("retires", retires, 8);
      chk("fwds", fwds, 1);
      chk("fill_busy", fill_busy, 0);
   endtask
   // Load, dependent, vector memory and store latencies in one set; its store is the first to the line just filled
   task test_mixed;
      dps_set_type m;
      m.ops = {{1'b1, DPS_K_STORE, 3'h0, 8'h5a}, {1'b1, DPS_K_VEC_MEM, 3'h0, 8'h00},
               {1'b1, DPS_K_PLAIN, 3'h1, 8'h00}, {1'b1, DPS_K_LOAD, 3'h0, 8'h00}};
      chk("fresh_written", dut.s.fresh_written, 0);
      send(OK_I, OK_I, m, 0);
      chk("fresh_written", dut.s.fresh_written, 1);
      drain();
   endtask
   initial
   begin
      repeat (12) @(posedge ref_clk);
      reset <= 1'b0;
      @(negedge ref_clk);
      test_reset();
      test_flow();
      test_predecode();
      test_stall();
      test_mixed();
      finish_test();
   end
endmodule
